// >>> mqf_pkg.sv
package mqf_pkg;

    // Queue and flag bus organisation
    localparam int QUEUES = 32;
    localparam int QADDR_W = 5;
    localparam int QUAD_BITS = 8;
    localparam int QUAD_W = 2;
    localparam logic [QUAD_W-1:0] QUAD_FIRST = 2'h0;
    localparam logic [QUAD_W-1:0] QUAD_LAST = 2'h3;

    // Memory pool: one block is 512 x 18 or 1,024 x 9, kept as 9-bit units
    localparam int BLOCKS_SMALL = 128;
    localparam int BLOCKS_LARGE = 256;
    localparam int BLK_SHIFT = 10;
    localparam int BLOCK_UNITS = 1 << BLK_SHIFT;
    localparam int UNIT_W = 9;
    localparam int DATA_W = 18;
    localparam int BLK_W = 9;
    localparam int OFF_W = 16;

    // APB register map, byte addresses
    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000;
    localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h004;
    localparam logic [APB_AW-1:0] ADDR_QCFG = 12'h100;
    localparam logic [APB_AW-1:0] ADDR_AFOFF = 12'h200;
    localparam logic [APB_AW-1:0] ADDR_AEOFF = 12'h300;
    localparam logic [APB_AW-1:0] ADDR_LEVEL = 12'h400;

    // Field positions
    localparam int CTRL_POLLED_BIT = 0;
    localparam int CTRL_IN18_BIT = 1;
    localparam int CTRL_OUT18_BIT = 2;
    localparam int CTRL_NQ_LSB = 8;
    localparam int NQ_W = 6;
    localparam int QCFG_BASE_LSB = 0;
    localparam int QCFG_CNT_LSB = 16;
    localparam int STAT_FULL_BIT = 0;
    localparam int STAT_OV_BIT = 1;
    localparam int STAT_RQ_LSB = 4;

    // Reset values
    localparam logic [31:0] CTRL_MASK = 32'h0000_3f07;
    localparam logic [31:0] CTRL_RST = 32'h0000_2006;
    localparam logic [OFF_W-1:0] OFF_RST = 16'h0008;

    // Pin groups of the two ports
    typedef struct packed {
        logic wen;
        logic strobe;
        logic [QADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mqf_wr_t;

    typedef struct packed {
        logic ren;
        logic strobe;
        logic [QADDR_W-1:0] addr;
    } mqf_rd_t;

endpackage

// >>> mqf_multi_queue_fifo.sv
`timescale 1ns/1ps
module mqf_multi_queue_fifo #(
    parameter int NUM_BLOCKS = mqf_pkg::BLOCKS_SMALL
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic [mqf_pkg::APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Write port pins
    input wire mqf_pkg::mqf_wr_t wrPort,
    output logic queueFullFlag,
    output logic almostFullFlag,
    output logic [mqf_pkg::QUAD_BITS-1:0] almostFullStatusBus,
    output logic fullBusSync,
    // Read port pins
    input wire mqf_pkg::mqf_rd_t rdPort,
    output logic [mqf_pkg::DATA_W-1:0] readData,
    output logic outputValidFlag,
    output logic almostEmptyFlag,
    output logic [mqf_pkg::QUAD_BITS-1:0] almostEmptyStatusBus,
    output logic emptyBusSync
);
    import mqf_pkg::*;

    localparam int MEM_UNITS = NUM_BLOCKS * BLOCK_UNITS;
    localparam int UA_W = $clog2(MEM_UNITS);
    localparam int CNT_W = UA_W + 1;

    // Pin synchronisers
    mqf_wr_t wrMeta_reg, wrSync_reg;
    mqf_rd_t rdMeta_reg, rdSync_reg;
    // Configuration
    logic [31:0] ctrl_reg;
    logic [BLK_W-1:0] baseBlk_reg [QUEUES];
    logic [BLK_W-1:0] nBlk_reg [QUEUES];
    logic [OFF_W-1:0] afOff_reg [QUEUES];
    logic [OFF_W-1:0] aeOff_reg [QUEUES];
    // Queue state and storage
    logic [CNT_W-1:0] cnt_reg [QUEUES];
    logic [CNT_W-1:0] wrPtr_reg [QUEUES];
    logic [CNT_W-1:0] rdPtr_reg [QUEUES];
    logic [UNIT_W-1:0] mem_reg [MEM_UNITS];
    // Read side and flag bus state
    logic [QADDR_W-1:0] curQ_reg;
    logic [QUAD_W-1:0] afQuad_reg, aeQuad_reg;
    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    logic fullFlag_reg, afFlag_reg, aeFlag_reg, ov_reg, afSync_reg, aeSync_reg;
    logic [QUAD_BITS-1:0] afBus_reg, aeBus_reg;
    logic [DATA_W-1:0] rdData_reg;

    // Derived values
    logic polled, in18, out18;
    logic [NQ_W-1:0] numQ;
    logic [CNT_W-1:0] inU, outU;
    logic [CNT_W-1:0] cap [QUEUES];
    logic [CNT_W-1:0] baseU [QUEUES];
    logic [QUEUES-1:0] fullVec, afVec, aeVec, cfgRst;
    logic [QADDR_W-1:0] wq, rq;
    logic push, pop, availNext;
    logic [CNT_W-1:0] headNext, cntNext;
    logic [UA_W-1:0] wrAddr, rdAddr;
    logic [DATA_W-1:0] headWord;
    logic [QUAD_W-1:0] afQuadNext, aeQuadNext;
    logic apbSetup, apbWr, apbHit, qRegion;
    logic [QADDR_W-1:0] qIdx;
    logic [APB_AW-1:0] regionBase;
    logic [31:0] rdMux;

    function automatic logic [CNT_W-1:0] stepPtr(input logic [CNT_W-1:0] p,
                                                 input logic [CNT_W-1:0] s,
                                                 input logic [CNT_W-1:0] c);
        logic [CNT_W-1:0] n;
        n = p + s;
        return (n >= c) ? n - c : n;
    endfunction

    // Two flops on every pin input, nothing reads the first
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wrMeta_reg <= '0;
            wrSync_reg <= '0;
            rdMeta_reg <= '0;
            rdSync_reg <= '0;
        end else begin
            wrMeta_reg <= wrPort;
            wrSync_reg <= wrMeta_reg;
            rdMeta_reg <= rdPort;
            rdSync_reg <= rdMeta_reg;
        end
    end

    // Global settings shared by all queues
    assign polled = ctrl_reg[CTRL_POLLED_BIT];
    assign in18 = ctrl_reg[CTRL_IN18_BIT];
    assign out18 = ctrl_reg[CTRL_OUT18_BIT];
    assign numQ = ctrl_reg[CTRL_NQ_LSB +: NQ_W];
    assign inU = in18 ? CNT_W'(2) : CNT_W'(1);
    assign outU = out18 ? CNT_W'(2) : CNT_W'(1);
    assign wq = wrSync_reg.addr;
    assign rq = rdSync_reg.addr;

    // Per-queue capacity and flags; queues past the active count hold nothing
    always_comb begin
        for (int q = 0; q < QUEUES; q++) begin
            cap[q] = (q < int'(numQ)) ? CNT_W'(nBlk_reg[q]) << BLK_SHIFT : '0;
            baseU[q] = CNT_W'(baseBlk_reg[q]) << BLK_SHIFT;
            fullVec[q] = (cnt_reg[q] + inU) > cap[q];
            afVec[q] = (cap[q] - cnt_reg[q]) <= (CNT_W'(afOff_reg[q]) << in18);
            aeVec[q] = cnt_reg[q] <= (CNT_W'(aeOff_reg[q]) << out18);
        end
    end

    // Write accept and read pop; pop only consumes a word already shown
    assign push = wrSync_reg.wen && !fullVec[wq];
    assign pop = rdSync_reg.ren && ov_reg && (rq == curQ_reg);
    assign headNext = pop ? stepPtr(rdPtr_reg[rq], outU, cap[rq]) : rdPtr_reg[rq];
    assign cntNext = pop ? cnt_reg[rq] - outU : cnt_reg[rq];
    assign availNext = (cntNext >= outU) && !cfgRst[rq];
    assign wrAddr = UA_W'(baseU[wq] + wrPtr_reg[wq]);
    assign rdAddr = UA_W'(baseU[rq] + headNext);
    // Little endian: lower unit address is the low half of an x18 word
    assign headWord = out18 ? {mem_reg[UA_W'(rdAddr + 1'b1)], mem_reg[rdAddr]}
                            : {{(DATA_W - UNIT_W){1'b0}}, mem_reg[rdAddr]};

    // Storage; an x18 write fills two units, capacities are always even
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_reg[wrAddr] <= wrSync_reg.data[UNIT_W-1:0];
            if (in18) begin
                mem_reg[UA_W'(wrAddr + 1'b1)] <= wrSync_reg.data[DATA_W-1:UNIT_W];
            end
        end
    end

    // Levels and pointers; a reconfigured queue is emptied
    always_ff @(posedge ref_clk) begin
        for (int q = 0; q < QUEUES; q++) begin
            if (rst || cfgRst[q]) begin
                cnt_reg[q] <= '0;
                wrPtr_reg[q] <= '0;
                rdPtr_reg[q] <= '0;
            end else begin
                cnt_reg[q] <= cnt_reg[q] + ((push && wq == q) ? inU : '0)
                              - ((pop && curQ_reg == q) ? outU : '0);
                if (push && wq == q) begin
                    wrPtr_reg[q] <= stepPtr(wrPtr_reg[q], inU, cap[q]);
                end
                if (pop && curQ_reg == q) begin
                    rdPtr_reg[q] <= stepPtr(rdPtr_reg[q], outU, cap[q]);
                end
            end
        end
    end

    // Output register: head of the selected queue, held when it is empty
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            curQ_reg <= '0;
            ov_reg <= 1'b0;
            rdData_reg <= '0;
        end else begin
            curQ_reg <= rq;
            ov_reg <= availNext;
            if (availNext) begin
                rdData_reg <= headWord;
            end
        end
    end

    // Dedicated flags, one cycle behind the selection
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fullFlag_reg <= 1'b0;
            afFlag_reg <= 1'b0;
            aeFlag_reg <= 1'b0;
        end else begin
            fullFlag_reg <= fullVec[wq];
            afFlag_reg <= afVec[wq];
            aeFlag_reg <= aeVec[rq];
        end
    end

    // Quadrant choice: step in polled mode, strobe-latched in direct mode
    always_comb begin
        if (polled) begin
            afQuadNext = afQuad_reg + 1'b1;
            aeQuadNext = aeQuad_reg + 1'b1;
        end else begin
            afQuadNext = wrSync_reg.strobe ? wrSync_reg.addr[QUAD_W-1:0] : afQuad_reg;
            aeQuadNext = rdSync_reg.strobe ? rdSync_reg.addr[QUAD_W-1:0] : aeQuad_reg;
        end
    end

    // Status buses; a mode write restarts both so they stay in step
    always_ff @(posedge ref_clk) begin
        if (rst || cfgRst[0] && apbWr && paddr == ADDR_CTRL) begin
            afQuad_reg <= QUAD_LAST;
            aeQuad_reg <= QUAD_LAST;
            afBus_reg <= '0;
            aeBus_reg <= '0;
            afSync_reg <= 1'b0;
            aeSync_reg <= 1'b0;
        end else begin
            afQuad_reg <= afQuadNext;
            aeQuad_reg <= aeQuadNext;
            afBus_reg <= afVec[{afQuadNext, 3'h0} +: QUAD_BITS];
            aeBus_reg <= aeVec[{aeQuadNext, 3'h0} +: QUAD_BITS];
            afSync_reg <= polled && (afQuadNext == QUAD_FIRST);
            aeSync_reg <= polled && (aeQuadNext == QUAD_FIRST);
        end
    end

    // APB decode: one setup cycle, answer in the first access cycle
    assign apbSetup = psel && !penable;
    assign apbWr = psel && penable && pready_reg && pwrite && !pslverr_reg;
    assign regionBase = {paddr[APB_AW-1:7], 7'h00};
    assign qIdx = paddr[6:2];
    assign qRegion = (paddr[1:0] == 2'h0) && (regionBase == ADDR_QCFG || regionBase == ADDR_AFOFF
                     || regionBase == ADDR_AEOFF || regionBase == ADDR_LEVEL);
    assign apbHit = qRegion || paddr == ADDR_CTRL || paddr == ADDR_STATUS;

    // Reconfiguring a queue, or the global setup, flushes its contents
    always_comb begin
        for (int q = 0; q < QUEUES; q++) begin
            cfgRst[q] = apbWr && (paddr == ADDR_CTRL || (regionBase == ADDR_QCFG && qIdx == q));
        end
    end

    // Read data mux, sampled in the setup cycle
    always_comb begin
        rdMux = '0;
        if (paddr == ADDR_CTRL) begin
            rdMux = ctrl_reg;
        end else if (paddr == ADDR_STATUS) begin
            rdMux[STAT_FULL_BIT] = fullFlag_reg;
            rdMux[STAT_OV_BIT] = ov_reg;
            rdMux[STAT_RQ_LSB +: QADDR_W] = curQ_reg;
        end else if (regionBase == ADDR_QCFG) begin
            rdMux[QCFG_BASE_LSB +: BLK_W] = baseBlk_reg[qIdx];
            rdMux[QCFG_CNT_LSB +: BLK_W] = nBlk_reg[qIdx];
        end else if (regionBase == ADDR_AFOFF) begin
            rdMux[OFF_W-1:0] = afOff_reg[qIdx];
        end else if (regionBase == ADDR_AEOFF) begin
            rdMux[OFF_W-1:0] = aeOff_reg[qIdx];
        end else if (regionBase == ADDR_LEVEL) begin
            rdMux[CNT_W-1:0] = cnt_reg[qIdx];
        end
    end

    // APB handshake flops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= apbSetup;
            pslverr_reg <= apbSetup && !apbHit;
            if (apbSetup) begin
                prdata_reg <= apbHit ? rdMux : '0;
            end
        end
    end

    // Configuration registers; default spreads the pool evenly
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_reg <= CTRL_RST;
            for (int q = 0; q < QUEUES; q++) begin
                baseBlk_reg[q] <= BLK_W'(q * (NUM_BLOCKS / QUEUES));
                nBlk_reg[q] <= BLK_W'(NUM_BLOCKS / QUEUES);
                afOff_reg[q] <= OFF_RST;
                aeOff_reg[q] <= OFF_RST;
            end
        end else if (apbWr) begin
            if (paddr == ADDR_CTRL) begin
                ctrl_reg <= pwdata & CTRL_MASK;
            end
            if (regionBase == ADDR_QCFG) begin
                baseBlk_reg[qIdx] <= pwdata[QCFG_BASE_LSB +: BLK_W];
                nBlk_reg[qIdx] <= pwdata[QCFG_CNT_LSB +: BLK_W];
            end
            if (regionBase == ADDR_AFOFF) begin
                afOff_reg[qIdx] <= pwdata[OFF_W-1:0];
            end
            if (regionBase == ADDR_AEOFF) begin
                aeOff_reg[qIdx] <= pwdata[OFF_W-1:0];
            end
        end
    end

    // Every output straight from a flop
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign queueFullFlag = fullFlag_reg;
    assign almostFullFlag = afFlag_reg;
    assign almostFullStatusBus = afBus_reg;
    assign fullBusSync = afSync_reg;
    assign readData = rdData_reg;
    assign outputValidFlag = ov_reg;
    assign almostEmptyFlag = aeFlag_reg;
    assign almostEmptyStatusBus = aeBus_reg;
    assign emptyBusSync = aeSync_reg;

    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    write_block_a: assert property (
        (wrSync_reg.wen && fullVec[wq] && !pop && !cfgRst[wq])
        |=> cnt_reg[$past(wq)] == $past(cnt_reg[wq]))
        else $error("write accepted into a full queue");
    capacity_bound_a: assert property (
        fullFlag_reg |-> $past(cnt_reg[wq] + inU > cap[wq]))
        else $error("full flag without a full queue");
    fall_through_a: assert property (
        (rq != curQ_reg && availNext) |=> outputValidFlag && readData == $past(headWord))
        else $error("newly selected word did not fall through");
    read_hold_a: assert property (
        (ov_reg && !rdSync_reg.ren && rq == curQ_reg && !cfgRst[rq] && !$changed(ctrl_reg))
        |=> outputValidFlag && $stable(readData))
        else $error("output advanced without read enable");
    keep_last_a: assert property (
        !availNext |=> !outputValidFlag && $stable(readData))
        else $error("output changed from an empty queue");
    sync_quad1_a: assert property (
        (polled && $past(polled) && aeQuad_reg == QUAD_FIRST) |-> emptyBusSync)
        else $error("empty bus sync missing on quadrant one");
    poll_wrap_a: assert property (
        (polled && aeQuad_reg == QUAD_LAST && !(apbWr && paddr == ADDR_CTRL)) ##1 polled
        |-> aeQuad_reg == QUAD_FIRST)
        else $error("polled sequence did not wrap");
    poll_step_a: assert property (
        (polled && !(apbWr && paddr == ADDR_CTRL)) |=> afQuad_reg == $past(afQuad_reg) + 2'h1)
        else $error("polled quadrant did not advance");
    mode_same_a: assert property (
        (polled && $past(polled)) |-> afQuad_reg == aeQuad_reg)
        else $error("status buses out of step in polled mode");
    direct_latch_a: assert property (
        (!polled && rdSync_reg.strobe && !cfgRst[0])
        |=> aeQuad_reg == $past(rdSync_reg.addr[QUAD_W-1:0]))
        else $error("direct quadrant not latched");

endmodule // mqf_multi_queue_fifo

// >>> mqf_host_model.sv
`timescale 1ns/1ps
module mqf_host_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Commands from the bench
    input wire logic wrGo,
    input wire logic fullStb,
    input wire logic [mqf_pkg::QADDR_W-1:0] wrQueue,
    input wire logic [mqf_pkg::DATA_W-1:0] wrWord,
    input wire logic rdGo,
    input wire logic emptyStb,
    input wire logic [mqf_pkg::QADDR_W-1:0] rdQueue,
    // Pins toward the device
    output mqf_pkg::mqf_wr_t wrPort,
    output mqf_pkg::mqf_rd_t rdPort
);
    import mqf_pkg::*;

    // Writer; idle data toggles so a stale word can never pass for a fresh one
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wrPort <= '0;
        end else begin
            wrPort.wen <= wrGo;
            wrPort.strobe <= fullStb;
            wrPort.addr <= wrQueue;
            wrPort.data <= wrGo ? wrWord : ~wrPort.data;
        end
    end

    // Reader; enable only for words after the fall-through one
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdPort <= '0;
        end else begin
            rdPort.ren <= rdGo;
            rdPort.strobe <= emptyStb;
            rdPort.addr <= rdQueue;
        end
    end
endmodule // mqf_host_model

// >>> mqf_multi_queue_fifo_test.sv
`timescale 1ns/1ps
module mqf_multi_queue_fifo_test;
    import mqf_pkg::*;

    // Clock, reset and APB
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [APB_AW-1:0] paddr = '0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = '0, prdata, rdv;
    logic pready, pslverr, errv;
    // Host model commands
    logic wrGo = 1'b0, fullStb = 1'b0, rdGo = 1'b0, emptyStb = 1'b0;
    logic [QADDR_W-1:0] wrQueue = '0, rdQueue = '0;
    logic [DATA_W-1:0] wrWord = '0;
    // Device pins
    mqf_wr_t wrPort;
    mqf_rd_t rdPort;
    logic queueFullFlag, almostFullFlag, fullBusSync;
    logic outputValidFlag, almostEmptyFlag, emptyBusSync;
    logic [QUAD_BITS-1:0] almostFullStatusBus, almostEmptyStatusBus;
    logic [DATA_W-1:0] readData;
    int errorCnt = 0;
    int checked = 0;

    always #2.5 ref_clk = ~ref_clk;

    // Small pool: one block per queue keeps the fill test short
    mqf_multi_queue_fifo #(.NUM_BLOCKS(32)) uut (
        .ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wrPort(wrPort), .queueFullFlag(queueFullFlag), .almostFullFlag(almostFullFlag),
        .almostFullStatusBus(almostFullStatusBus), .fullBusSync(fullBusSync), .rdPort(rdPort),
        .readData(readData), .outputValidFlag(outputValidFlag),
        .almostEmptyFlag(almostEmptyFlag), .almostEmptyStatusBus(almostEmptyStatusBus),
        .emptyBusSync(emptyBusSync)
    );

    mqf_host_model host (
        .ref_clk(ref_clk), .rst(rst), .wrGo(wrGo), .fullStb(fullStb), .wrQueue(wrQueue),
        .wrWord(wrWord), .rdGo(rdGo), .emptyStb(emptyStb), .rdQueue(rdQueue),
        .wrPort(wrPort), .rdPort(rdPort)
    );

    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            errorCnt++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    // Ends mid-cycle so outputs are read well clear of the edge
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // One APB transfer; request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            $display("[ERR] %0t bus timeout", $time);
            errorCnt++;
            stop_test();
        end
        // Answer taken at the same edge that saw pready, then released
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic ctrl_wr(input logic [31:0] d);
        apb(1'b1, ADDR_CTRL, d, rdv, errv);
        settle(4);
    endtask

    // Back-to-back writes of consecutive words
    task automatic wr_burst(input logic [QADDR_W-1:0] q, input int n, input logic [DATA_W-1:0] d);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            wrGo <= 1'b1;
            wrQueue <= q;
            wrWord <= d + DATA_W'(i);
        end
        @(posedge ref_clk);
        wrGo <= 1'b0;
        settle(8);
    endtask

    task automatic rd_sel(input logic [QADDR_W-1:0] q);
        @(posedge ref_clk);
        rdQueue <= q;
        settle(8);
    endtask

    task automatic pop();
        @(posedge ref_clk);
        rdGo <= 1'b1;
        @(posedge ref_clk);
        rdGo <= 1'b0;
        settle(8);
    endtask

    // Direct quadrant pick; the queue address bus carries the quadrant
    task automatic quad(input logic wside, input logic [1:0] qd);
        @(posedge ref_clk);
        wrQueue <= wside ? {3'h0, qd} : wrQueue;
        rdQueue <= wside ? rdQueue : {3'h0, qd};
        fullStb <= wside;
        emptyStb <= !wside;
        @(posedge ref_clk);
        fullStb <= 1'b0;
        emptyStb <= 1'b0;
        settle(8);
    endtask

    task automatic t_regs();
        apb(1'b0, ADDR_CTRL, '0, rdv, errv);
        chk(rdv, CTRL_RST, "ctrl reset");
        apb(1'b0, ADDR_AEOFF + 12'h004, '0, rdv, errv);
        chk(rdv, 32'(OFF_RST), "offset reset");
        apb(1'b0, 12'hffc, '0, rdv, errv);
        chk({errv, rdv[30:0]}, 32'h8000_0000, "unmapped access");
        $display("register test done");
    endtask

    task automatic t_first_word_fall_through();
        rd_sel(5'h03);
        chk(32'({outputValidFlag, almostEmptyFlag}), 32'h1, "empty queue flags");
        wr_burst(5'h03, 2, 18'h010a5);
        chk(32'({outputValidFlag, readData}), 32'h410a5, "fall through");
        apb(1'b0, ADDR_LEVEL + 12'h00c, '0, rdv, errv);
        chk(rdv, 32'h4, "stored units");
        pop();
        chk(32'(readData), 32'h10a6, "second word");
        rd_sel(5'h09);
        chk(32'({outputValidFlag, readData}), 32'h10a6, "switch to empty");
        rd_sel(5'h03);
        chk(32'({outputValidFlag, readData}), 32'h410a6, "word kept in queue");
        pop();
        chk(32'({outputValidFlag, readData}), 32'h10a6, "drained queue");
        $display("fall-through test done");
    endtask

    task automatic t_full();
        wr_burst(5'h05, 503, 18'h0);
        chk(32'(almostFullFlag), 32'h0, "free above offset");
        wr_burst(5'h05, 1, 18'h1f7);
        chk(32'({almostFullFlag, queueFullFlag}), 32'h2, "free at offset");
        wr_burst(5'h05, 8, 18'h1f8);
        chk(32'(queueFullFlag), 32'h1, "full at capacity");
        wr_burst(5'h05, 1, 18'h3ffff);
        apb(1'b0, ADDR_LEVEL + 12'h014, '0, rdv, errv);
        chk(rdv, 32'h400, "write to full dropped");
        quad(1'b1, 2'h0);
        chk(32'(almostFullStatusBus), 32'h20, "full bus quadrant 1");
        quad(1'b1, 2'h1);
        chk(32'(almostFullStatusBus), 32'h0, "full bus quadrant 2");
        wr_burst(5'h0a, 20, 18'h0);
        quad(1'b0, 2'h1);
        chk(32'(almostEmptyStatusBus), 32'hfb, "empty bus quadrant 2");
        quad(1'b0, 2'h0);
        chk(32'(almostEmptyStatusBus), 32'hdf, "empty bus quadrant 1");
        $display("full and direct bus test done");
    endtask

    task automatic t_modes();
        int hits;
        // Output x9: an x18 word leaves in two halves, low half first
        ctrl_wr(32'h0000_2002);
        rd_sel(5'h04);
        wr_burst(5'h04, 1, 18'h2a5c3);
        chk(32'(readData), 32'h1c3, "x9 low half");
        pop();
        chk(32'(readData), 32'h152, "x9 high half");
        // Input x9 too: only the low nine data pins land, one unit per word
        ctrl_wr(32'h0000_2000);
        wr_burst(5'h04, 1, 18'h3f0ab);
        chk(32'({outputValidFlag, readData}), 32'h400ab, "x9 in fall through");
        apb(1'b0, ADDR_LEVEL + 12'h010, '0, rdv, errv);
        chk(rdv, 32'h1, "x9 in one unit");
        // One active queue: every other queue has no room
        ctrl_wr(32'h0000_0106);
        wr_burst(5'h01, 1, 18'h0);
        chk(32'(queueFullFlag), 32'h1, "inactive queue full");
        wr_burst(5'h00, 1, 18'h0);
        chk(32'(queueFullFlag), 32'h0, "active queue room");
        // Polled buses
        ctrl_wr(32'h0000_2007);
        wr_burst(5'h02, 20, 18'h0);
        hits = 0;
        for (int i = 0; i < 12; i++) begin
            @(negedge ref_clk);
            hits += int'(emptyBusSync === 1'b1);
            chk(32'(fullBusSync), 32'(emptyBusSync), "sync alignment");
            chk(32'(almostEmptyStatusBus), (emptyBusSync === 1'b1) ? 32'hfb : 32'hff,
                "polled quadrant");
        end
        chk(32'(hits), 32'h3, "sync every fourth cycle");
        $display("mode test done");
    endtask

    // Main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        settle(4);
        t_regs();
        t_first_word_fall_through();
        t_full();
        t_modes();
        stop_test();
    end

    // Watchdog against a hang
    initial begin
        #100000;
        $display("[ERR] %0t run timed out", $time);
        errorCnt++;
        stop_test();
    end
endmodule // mqf_multi_queue_fifo_test
